// ---- rtl/tbcp_map.svh ----
// Notes on behaviour
// - Packet tag copied unchanged to status output.
// - CRC disable bit suppresses appended CRC.
// - Pad disable bit suppresses short-frame padding.
// - With padding disabled, CRC always appended.
// - Packet length field counts payload bytes only.
// - Length mismatch with supplied bytes sets error.
// - First two words are command words.
// - Offset low bits pick first byte lane.
// - Offset high bits skip zero to seven words.
// - Unused trailing bytes never forwarded.
// - End alignment padding discarded, never sent.
// - Any start/end byte; first/last any length.
// - Command words and whole offset words stripped.
// - Worst buffer overhead 70 bytes: 8 command, 31 offset, 31 end pad.
// - First command bits 20:16 give start offset.
// - First command bits 13/12 mark first/last buffer.
// - Buffer sizes summed, compared with packet length.
// - Second command must match across buffers.
`ifndef TBCP_MAP_SVH
`define TBCP_MAP_SVH

// Register offsets (byte addresses)
`define TBCP_REG_CTRL 8'h00
`define TBCP_REG_STATUS 8'h04
`define TBCP_REG_LAST_TAG 8'h08
`define TBCP_REG_ERR_CNT 8'h0C

// Reset values
`define TBCP_CTRL_RST 1'h1

// Command A fields
`define TBCP_A_ALIGN_HI 25
`define TBCP_A_ALIGN_LO 24
`define TBCP_A_OFF_HI 20
`define TBCP_A_OFF_LO 16
`define TBCP_A_FIRST 13
`define TBCP_A_LAST 12
`define TBCP_A_SIZE_HI 10

// Command B fields
`define TBCP_B_TAG_HI 31
`define TBCP_B_TAG_LO 16
`define TBCP_B_CRC_DIS 13
`define TBCP_B_PAD_DIS 12
`define TBCP_B_LEN_HI 10

// Alignment masks in bytes
`define TBCP_ALIGN_M4 12'h003
`define TBCP_ALIGN_M16 12'h00F
`define TBCP_ALIGN_M32 12'h01F

// Minimum frame before the four-byte CRC
`define TBCP_MIN_FRAME 12'h03C

`endif

// ---- rtl/tbcp_parser.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "tbcp_map.svh"

module tbcp_parser
   import tbcp_pkg::*;
#(
   // Saturating error counter width
   parameter int unsigned ERR_CNT_W = 8
)
(
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic sys_rst_i,
   // Register port
   input wire logic [7:0] reg_addr_i,
   input wire logic [31:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [31:0] reg_rdata_o,
   // Transmit data FIFO words
   input wire logic in_valid_i,
   input wire logic [31:0] in_data_i,
   output logic in_ready_o,
   // Store-buffer byte stream
   output logic mac_valid_o,
   output logic [7:0] mac_byte_o,
   output logic mac_eop_o,
   output logic mac_crc_en_o,
   output logic [15:0] mac_tag_o,
   output logic mac_err_o,
   input wire logic mac_ready_i,
   // Error flag
   output logic tx_error_flag_o
);

   ////////////////////////////////////////////////////////////////////////
   tbcp_state_t state_q, state_d;
   logic [31:0] cmd_a_q;
   logic [31:0] cmd_b_q;
   logic [31:0] word_q;
   logic [1:0] lane_q;
   logic [9:0] dw_idx_q;
   logic [10:0] pay_cnt_q;
   logic [11:0] frame_cnt_q;
   logic [11:0] size_sum_q;
   logic b_mismatch_q;
   logic in_pkt_q;
   logic ctrl_en_q;
   logic [15:0] last_tag_q;
   logic [ERR_CNT_W-1:0] err_cnt_q;

   logic take;
   logic slot_free;
   logic [4:0] off;
   logic [10:0] bsize;
   logic [11:0] amask;
   logic [11:0] span_end;
   logic [11:0] rounded;
   logic [9:0] total_dw;
   logic [11:0] byte_pos;
   logic lane_hit;
   logic is_first;
   logic emit_byte;
   logic pkt_err;

   // Counter must fit the 32-bit read port; one bit could never saturate usefully
   if (ERR_CNT_W < 2 || ERR_CNT_W > 32) begin : g_bad_err_cnt_w
      $error("error counter width out of range");
   end

   // Handshakes
   assign take = in_valid_i & in_ready_o;
   assign slot_free = ~mac_valid_o | mac_ready_i;
   assign off = cmd_a_q[`TBCP_A_OFF_HI:`TBCP_A_OFF_LO];
   assign bsize = cmd_a_q[`TBCP_A_SIZE_HI:0];
   assign is_first = cmd_a_q[`TBCP_A_FIRST];

   // Whole buffer span incl. offset, rounded up to the host alignment
   always_comb begin
      unique case (cmd_a_q[`TBCP_A_ALIGN_HI:`TBCP_A_ALIGN_LO])
         2'h1: amask = `TBCP_ALIGN_M16;
         2'h2: amask = `TBCP_ALIGN_M32;
         default: amask = `TBCP_ALIGN_M4;
      endcase
   end

   assign span_end = {7'h00, off} + {1'h0, bsize};
   assign rounded = (span_end + amask) & ~amask;
   assign total_dw = rounded[11:2];

   // Byte in range only between offset and offset plus size
   assign byte_pos = {dw_idx_q, lane_q};
   assign lane_hit = (byte_pos >= {7'h00, off}) && (byte_pos < span_end);
   assign emit_byte = (state_q == TBCP_ST_EMIT) && lane_hit && slot_free;

   // Length and command B match checks at frame end
   assign pkt_err = (pay_cnt_q != cmd_b_q[`TBCP_B_LEN_HI:0])
      || (size_sum_q != {1'h0, cmd_b_q[`TBCP_B_LEN_HI:0]})
      || b_mismatch_q;

   ////////////////////////////////////////////////////////////////////////
   always_comb begin
      state_d = state_q;
      unique case (state_q)
         TBCP_ST_CMD_A: begin
            if (take) begin
               state_d = TBCP_ST_CMD_B;
            end
         end
         TBCP_ST_CMD_B: begin
            if (take) begin
               if (total_dw == 10'h000) begin
                  state_d = cmd_a_q[`TBCP_A_LAST] ? TBCP_ST_PAD : TBCP_ST_CMD_A;
               end else begin
                  state_d = TBCP_ST_DATA;
               end
            end
         end
         TBCP_ST_DATA: begin
            if (take) begin
               state_d = TBCP_ST_EMIT;
            end
         end
         TBCP_ST_EMIT: begin
            if (!lane_hit || slot_free) begin
               if (lane_q == 2'h3) begin
                  if (dw_idx_q + 10'h001 != total_dw) begin
                     state_d = TBCP_ST_DATA;
                  end else if (cmd_a_q[`TBCP_A_LAST]) begin
                     state_d = TBCP_ST_PAD;
                  end else begin
                     state_d = TBCP_ST_CMD_A;
                  end
               end
            end
         end
         TBCP_ST_PAD: begin
            if (cmd_b_q[`TBCP_B_PAD_DIS] || frame_cnt_q >= `TBCP_MIN_FRAME) begin
               state_d = TBCP_ST_END;
            end
         end
         TBCP_ST_END: begin
            if (slot_free) begin
               state_d = TBCP_ST_CMD_A;
            end
         end
      endcase
   end

   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         state_q <= TBCP_ST_CMD_A;
      end else begin
         state_q <= state_d;
      end
   end

   // Ready from a flop, so it looks one state ahead
   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         in_ready_o <= 1'b0;
      end else begin
         in_ready_o <= ctrl_en_q && (state_d == TBCP_ST_CMD_A || state_d == TBCP_ST_CMD_B
            || state_d == TBCP_ST_DATA);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Command A is replaced with every buffer
   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         cmd_a_q <= 32'h0000_0000;
      end else if (take && state_q == TBCP_ST_CMD_A) begin
         cmd_a_q <= in_data_i;
      end
   end

   // Command B: only one copy is kept per packet
   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         cmd_b_q <= 32'h0000_0000;
         b_mismatch_q <= 1'b0;
         in_pkt_q <= 1'b0;
      end else if (take && state_q == TBCP_ST_CMD_B) begin
         if (is_first || !in_pkt_q) begin
            cmd_b_q <= in_data_i;
            b_mismatch_q <= 1'b0;
            in_pkt_q <= 1'b1;
         end else if (in_data_i != cmd_b_q) begin
            b_mismatch_q <= 1'b1;
         end
      end else if (state_q == TBCP_ST_END && slot_free) begin
         in_pkt_q <= 1'b0;
      end
   end

   // Running sum of buffer sizes within a packet
   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         size_sum_q <= 12'h000;
      end else if (take && state_q == TBCP_ST_CMD_B) begin
         if (is_first || !in_pkt_q) begin
            size_sum_q <= {1'h0, bsize};
         end else begin
            size_sum_q <= size_sum_q + {1'h0, bsize};
         end
      end
   end

   // Word walk: offset and alignment words are consumed into word_q but never emitted
   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         word_q <= 32'h0000_0000;
         lane_q <= 2'h0;
         dw_idx_q <= 10'h000;
      end else if (state_q == TBCP_ST_CMD_B) begin
         dw_idx_q <= 10'h000;
         lane_q <= 2'h0;
      end else if (take && state_q == TBCP_ST_DATA) begin
         word_q <= in_data_i;
         lane_q <= 2'h0;
      end else if (state_q == TBCP_ST_EMIT && (!lane_hit || slot_free)) begin
         lane_q <= lane_q + 2'h1;
         if (lane_q == 2'h3) begin
            dw_idx_q <= dw_idx_q + 10'h001;
         end
      end
   end

   // Payload and frame counters
   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         pay_cnt_q <= 11'h000;
         frame_cnt_q <= 12'h000;
      end else if (state_q == TBCP_ST_END && slot_free) begin
         pay_cnt_q <= 11'h000;
         frame_cnt_q <= 12'h000;
      end else if (emit_byte) begin
         pay_cnt_q <= pay_cnt_q + 11'h001;
         frame_cnt_q <= frame_cnt_q + 12'h001;
      end else if (state_q == TBCP_ST_PAD && state_d == TBCP_ST_PAD && slot_free) begin
         frame_cnt_q <= frame_cnt_q + 12'h001;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Output beat held until the store buffer takes it
   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         mac_valid_o <= 1'b0;
         mac_byte_o <= 8'h00;
         mac_eop_o <= 1'b0;
      end else if (slot_free) begin
         mac_valid_o <= 1'b0;
         mac_eop_o <= 1'b0;
         if (emit_byte) begin
            mac_valid_o <= 1'b1;
            mac_byte_o <= word_q[{lane_q, 3'h0} +: 8];
         end else if (state_q == TBCP_ST_PAD && state_d == TBCP_ST_PAD) begin
            mac_valid_o <= 1'b1;
            mac_byte_o <= 8'h00;
         end else if (state_q == TBCP_ST_END) begin
            mac_valid_o <= 1'b1;
            mac_eop_o <= 1'b1;
            mac_byte_o <= 8'h00;
         end
      end
   end

   // Frame sideband moves only when the end beat is launched
   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         mac_tag_o <= 16'h0000;
         mac_crc_en_o <= 1'b0;
         mac_err_o <= 1'b0;
      end else if (state_q == TBCP_ST_END && slot_free) begin
         mac_tag_o <= cmd_b_q[`TBCP_B_TAG_HI:`TBCP_B_TAG_LO];
         mac_crc_en_o <= ~cmd_b_q[`TBCP_B_CRC_DIS] | cmd_b_q[`TBCP_B_PAD_DIS];
         mac_err_o <= pkt_err;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Registers; error flag is write-one-to-clear, a new error wins
   logic err_event;
   assign err_event = (state_q == TBCP_ST_END) && slot_free && pkt_err;

   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         tx_error_flag_o <= 1'b0;
      end else if (err_event) begin
         tx_error_flag_o <= 1'b1;
      end else if (reg_wr_i && reg_addr_i == `TBCP_REG_STATUS && reg_wdata_i[0]) begin
         tx_error_flag_o <= 1'b0;
      end
   end

   // Last tag kept for software, error or not
   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         last_tag_q <= 16'h0000;
      end else if (state_q == TBCP_ST_END && slot_free) begin
         last_tag_q <= cmd_b_q[`TBCP_B_TAG_HI:`TBCP_B_TAG_LO];
      end
   end

   // Saturates rather than wraps so a burst of errors is never hidden
   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         err_cnt_q <= {ERR_CNT_W{1'b0}};
      end else if (err_event && err_cnt_q != {ERR_CNT_W{1'b1}}) begin
         err_cnt_q <= err_cnt_q + ERR_CNT_W'(1);
      end
   end

   // Disabling stalls the input only at the next word boundary
   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         ctrl_en_q <= `TBCP_CTRL_RST;
      end else if (reg_wr_i && reg_addr_i == `TBCP_REG_CTRL) begin
         ctrl_en_q <= reg_wdata_i[0];
      end
   end

   // Read data is zero outside its answer cycle
   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         reg_rdata_o <= 32'h0000_0000;
      end else if (reg_rd_i) begin
         unique case (reg_addr_i)
            `TBCP_REG_CTRL: reg_rdata_o <= {31'h0, ctrl_en_q};
            `TBCP_REG_STATUS: reg_rdata_o <= {30'h0, in_pkt_q, tx_error_flag_o};
            `TBCP_REG_LAST_TAG: reg_rdata_o <= {16'h0, last_tag_q};
            `TBCP_REG_ERR_CNT: reg_rdata_o <= 32'(err_cnt_q);
            default: reg_rdata_o <= 32'h0000_0000;
         endcase
      end else begin
         reg_rdata_o <= 32'h0000_0000;
      end
   end

endmodule

`default_nettype wire

// ---- rtl/tbcp_pkg.sv ----
package tbcp_pkg;

   typedef enum logic [2:0] {
      TBCP_ST_CMD_A,
      TBCP_ST_CMD_B,
      TBCP_ST_DATA,
      TBCP_ST_EMIT,
      TBCP_ST_PAD,
      TBCP_ST_END
   } tbcp_state_t;

endpackage

// ---- tb/tbcp_host.sv ----
`timescale 1ns/10ps
`default_nettype none
module tbcp_host (
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic sys_rst_i,
   // Transmit data FIFO words
   input wire logic in_ready_i,
   output logic in_valid_o = 1'h0,
   output logic [31:0] in_data_o = 32'h0
);
   logic [31:0] q[$];
   logic [8:0] exp_q[$];
   logic [7:0] nb = 8'h01;

   // Idle data keeps changing so a stale word never looks valid
   always @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         in_valid_o <= 1'h0;
      end else if (!in_valid_o || in_ready_i) begin
         if (q.size() > 0) begin
            in_valid_o <= 1'h1;
            in_data_o <= q.pop_front();
         end else begin
            in_valid_o <= 1'h0;
            in_data_o <= ~in_data_o;
         end
      end
   end

   // Buffers stay small and few per packet
   task automatic put_buf(input int off, size, input logic [1:0] al, input logic fs, ls, input logic [31:0] b);
      int am, p;
      logic [31:0] w;
      am = (al == 2'h1) ? 15 : (al == 2'h2) ? 31 : 3;
      q.push_back({6'h00, al, 3'h0, off[4:0], 2'h0, fs, ls, 1'h0, size[10:0]});
      q.push_back(b);
      w = 32'h0;
      for (p = 0; p < ((off + size + am) & ~am); p++) begin
         if (p >= off && p < off + size) begin
            w[8*(p%4) +: 8] = nb;
            exp_q.push_back({1'h0, nb});
            nb++;
         end else
            w[8*(p%4) +: 8] = 8'hA5;
         if (p % 4 == 3)
            q.push_back(w);
      end
   endtask
endmodule
`default_nettype wire

// ---- tb/tbcp_parser_props.sv ----
`timescale 1ns/10ps
`default_nettype none
module tbcp_parser_props (
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic sys_rst_i,
   // Register port
   input wire logic [7:0] reg_addr_i,
   input wire logic [31:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic [31:0] reg_rdata_o,
   // Byte stream and flag
   input wire logic mac_valid_o,
   input wire logic [7:0] mac_byte_o,
   input wire logic mac_eop_o,
   input wire logic mac_err_o,
   input wire logic mac_ready_i,
   input wire logic tx_error_flag_o
);
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (sys_rst_i);
   sequence eop_bad;
      mac_valid_o && $rose(mac_eop_o) && mac_err_o;
   endsequence
   sequence clr_wr;
      reg_wr_i && reg_addr_i == 8'h04 && reg_wdata_i[0];
   endsequence
   beat_hold_a: assert property (mac_valid_o && !mac_ready_i
      |=> mac_valid_o && $stable({mac_byte_o, mac_eop_o, mac_err_o})) else $error("beat changed while stalled");
   eop_empty_a: assert property (mac_valid_o && mac_eop_o |-> mac_byte_o == 8'h00)
      else $error("end beat carries a byte");
   err_set_a: assert property (eop_bad |-> tx_error_flag_o)
      else $error("error frame did not raise flag");
   flag_hold_a: assert property (tx_error_flag_o && !reg_wr_i |=> tx_error_flag_o)
      else $error("error flag lost");
   flag_clear_a: assert property (clr_wr |=> !tx_error_flag_o || (mac_eop_o && mac_err_o))
      else $error("error flag not cleared");
   status_rd_a: assert property (reg_rd_i && reg_addr_i == 8'h04
      |=> reg_rdata_o[0] == $past(tx_error_flag_o)) else $error("status read wrong");
   rdata_idle_a: assert property (!reg_rd_i |=> reg_rdata_o == 32'h0)
      else $error("read data outside read cycle");
   unmapped_a: assert property (reg_rd_i && reg_addr_i > 8'h0C |=> reg_rdata_o == 32'h0)
      else $error("unmapped read not zero");
endmodule
`default_nettype wire

// ---- tb/tbcp_parser_tb.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "tbcp_map.svh"
module tbcp_parser_tb;
   logic sys_clk_i = 1'h0, sys_rst_i = 1'h1;
   logic [7:0] reg_addr_i = 8'h00, mac_byte_o;
   logic [31:0] reg_wdata_i = 32'h0, reg_rdata_o, in_data_i;
   logic reg_wr_i = 1'h0, reg_rd_i = 1'h0, in_valid_i, in_ready_o, mac_ready_i = 1'h0;
   logic mac_valid_o, mac_eop_o, mac_crc_en_o, mac_err_o, tx_error_flag_o;
   logic [15:0] mac_tag_o;
   logic [17:0] eop_q[$];
   int miscompares = 0, check_count = 0, cyc = 0;

   tbcp_parser dut (.sys_clk_i, .sys_rst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
      .in_valid_i, .in_data_i, .in_ready_o, .mac_valid_o, .mac_byte_o, .mac_eop_o, .mac_crc_en_o,
      .mac_tag_o, .mac_err_o, .mac_ready_i, .tx_error_flag_o);
   tbcp_host host (.sys_clk_i, .sys_rst_i, .in_ready_i(in_ready_o), .in_valid_o(in_valid_i),
      .in_data_o(in_data_i));

   initial begin
      forever #25 sys_clk_i = ~sys_clk_i;
   end

   // Store side stalls one cycle in four
   always @(posedge sys_clk_i) begin
      cyc <= cyc + 1;
      mac_ready_i <= (cyc % 4) != 3;
   end

   task automatic chk(input logic [31:0] got, exp);
      check_count++;
      if (got !== exp) begin
         miscompares++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic stop_test();
      if (miscompares == 0 && check_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////
   always @(posedge sys_clk_i) begin
      if (mac_valid_o === 1'h1 && mac_ready_i) begin
         if (host.exp_q.size() == 0)
            chk(32'h1, 32'h0);
         else if (host.exp_q[0][8]) begin
            chk({mac_eop_o, mac_err_o, mac_crc_en_o, mac_tag_o}, {1'h1, eop_q.pop_front()});
            void'(host.exp_q.pop_front());
         end else
            chk({mac_eop_o, mac_byte_o}, host.exp_q.pop_front());
      end
   end

   task automatic rw(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk_i);
      reg_addr_i <= a;
      reg_wdata_i <= d;
      reg_wr_i <= wr;
      reg_rd_i <= !wr;
      @(posedge sys_clk_i);
      reg_wr_i <= 1'h0;
      reg_rd_i <= 1'h0;
      #1;
      if (!wr)
         chk(reg_rdata_o, d);
   endtask

   // Pads and end beat expected, then drain under a bound
   task automatic fin(input int len, input logic [31:0] b, input logic err);
      int i;
      for (i = len; i < `TBCP_MIN_FRAME && !b[12]; i++) host.exp_q.push_back(9'h000);
      host.exp_q.push_back(9'h100);
      eop_q.push_back({err, ~b[13] | b[12], b[31:16]});
      for (i = 0; i < 3000 && host.exp_q.size() > 0; i++) @(posedge sys_clk_i);
      if (host.exp_q.size() > 0) begin
         miscompares++;
         $display("Error at %0t: frame not finished", $time);
         stop_test();
      end
   endtask

   initial begin
      repeat (16) @(posedge sys_clk_i);
      sys_rst_i <= 1'h0;
      rw(1'h0, `TBCP_REG_CTRL, 32'h1);
      rw(1'h0, `TBCP_REG_STATUS, 32'h0);
      rw(1'h0, 8'h10, 32'h0);
      host.put_buf(5, 7, 2'h1, 1'h1, 1'h1, 32'h12342007);
      fin(7, 32'h12342007, 1'h0);
      host.put_buf(3, 2, 2'h0, 1'h1, 1'h0, 32'hBEEF3007);
      host.put_buf(0, 5, 2'h2, 1'h0, 1'h1, 32'hBEEF3007);
      fin(7, 32'hBEEF3007, 1'h0);
      rw(1'h1, `TBCP_REG_CTRL, 32'h0);
      rw(1'h0, `TBCP_REG_CTRL, 32'h0);
      host.put_buf(2, 4, 2'h0, 1'h1, 1'h1, 32'hC0DE0005);
      repeat (20) @(posedge sys_clk_i);
      chk(host.exp_q.size(), 32'h4);
      rw(1'h1, `TBCP_REG_CTRL, 32'h1);
      fin(4, 32'hC0DE0005, 1'h1);
      rw(1'h0, `TBCP_REG_STATUS, 32'h1);
      rw(1'h1, `TBCP_REG_STATUS, 32'h1);
      rw(1'h0, `TBCP_REG_STATUS, 32'h0);
      host.put_buf(0, 3, 2'h0, 1'h1, 1'h0, 32'hD00D1007);
      host.put_buf(1, 4, 2'h1, 1'h0, 1'h1, 32'hD00E1007);
      fin(7, 32'hD00D1007, 1'h1);
      rw(1'h0, `TBCP_REG_ERR_CNT, 32'h2);
      rw(1'h0, `TBCP_REG_LAST_TAG, 32'hD00D);
      stop_test();
   end
endmodule

bind tbcp_parser tbcp_parser_props chk (.sys_clk_i, .sys_rst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
   .reg_rd_i, .reg_rdata_o, .mac_valid_o, .mac_byte_o, .mac_eop_o, .mac_err_o, .mac_ready_i, .tx_error_flag_o);
`default_nettype wire
